/* hw/gxs_pkg.sv */
// Package: index map, field layout, constants and carriers of the bank
package gxs_pkg;

  // Register indices on the data port
  localparam logic [5:0] IDX_PASSWORD = 6'h05;
  localparam logic [5:0] IDX_RANGE_LO = 6'h05;
  localparam logic [5:0] IDX_RANGE_HI = 6'h37;
  localparam logic [5:0] IDX_SCRATCH0 = 6'h0F;
  localparam logic [5:0] IDX_SCRATCH1 = 6'h10;
  localparam logic [5:0] IDX_POWER = 6'h11;
  localparam logic [5:0] IDX_C0_RED = 6'h14;
  localparam logic [5:0] IDX_C0_GREEN = 6'h15;
  localparam logic [5:0] IDX_C0_BLUE = 6'h16;
  localparam logic [5:0] IDX_C1_RED = 6'h17;
  localparam logic [5:0] IDX_C1_GREEN = 6'h18;
  localparam logic [5:0] IDX_C1_BLUE = 6'h19;
  localparam logic [5:0] IDX_HSTART_LO = 6'h1A;
  localparam logic [5:0] IDX_HSTART_HI = 6'h1B;
  localparam logic [5:0] IDX_HPRESET = 6'h1C;
  localparam logic [5:0] IDX_VSTART_LO = 6'h1D;
  localparam logic [5:0] IDX_VSTART_HI = 6'h1E;
  localparam logic [5:0] IDX_VPRESET = 6'h1F;
  localparam logic [5:0] IDX_LBASE_LO = 6'h20;
  localparam logic [5:0] IDX_LBASE_HI = 6'h21;
  localparam logic [5:0] IDX_TIMERS = 6'h22;
  localparam logic [5:0] IDX_MISC3 = 6'h23;
  localparam logic [5:0] IDX_FB_LOC = 6'h24;
  localparam logic [5:0] IDX_SCRATCH2 = 6'h25;
  localparam logic [5:0] IDX_ENGINE0 = 6'h26;
  localparam logic [5:0] IDX_ENGINE1 = 6'h27;
  localparam logic [5:0] IDX_MCLK0 = 6'h28;
  localparam logic [5:0] IDX_MCLK1 = 6'h29;
  localparam logic [5:0] IDX_PCLK0 = 6'h2A;
  localparam logic [5:0] IDX_PCLK1 = 6'h2B;
  localparam logic [5:0] IDX_CQ_BASE = 6'h2C;

  // Password behaviour
  localparam logic [7:0] UNLOCK_KEY = 8'h86;
  localparam logic [7:0] ID_UNLOCKED = 8'hA1;
  localparam logic [7:0] ID_LOCKED = 8'h21;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Writable-bit masks
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_POWER = 8'hF3;
  localparam logic [7:0] MASK_SIX = 8'h3F;
  localparam logic [7:0] MASK_THREE = 8'h07;
  localparam logic [7:0] MASK_VSTART_HI = 8'hF7;
  localparam logic [7:0] MASK_SEVEN = 8'h7F;
  localparam logic [7:0] MASK_ENGINE1 = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // Power register bit positions
  localparam int PWR_SUSPEND = 7;
  localparam int PWR_STANDBY = 6;
  localparam int PWR_VMEM_WAKE = 5;
  localparam int PWR_KBD_WAKE = 4;
  localparam int PWR_LINK_DATA = 1;
  localparam int PWR_LINK_CLOCK = 0;

  // Scaled values
  localparam logic [4:0] TIMER_STEP_MIN = 5'h02;
  localparam logic [3:0] DELAY_BASE_NS = 4'h4;
  localparam logic [2:0] RAS_PRE_MCLK_FAST = 3'h3;
  localparam logic [2:0] RAS_PRE_MCLK_SLOW = 3'h4;
  localparam logic [3:0] DRAM_CYCLE_MCLK_FAST = 4'h7;
  localparam logic [3:0] DRAM_CYCLE_MCLK_SLOW = 4'h8;
  localparam logic [31:0] APERTURE_MIN_BYTES = 32'h0008_0000;
  localparam int FB_UNIT_SHIFT_32 = 18;
  localparam int FB_UNIT_SHIFT_64 = 19;
  localparam int LBASE_LO_SHIFT = 19;
  localparam logic [1:0] WIDTH_CODE_INVALID = 2'h3;
  localparam logic LINK_IDLE_LEVEL = 1'b1;

  typedef struct packed {
    logic force_suspend;
    logic force_standby;
    logic vmem_wake_en;
    logic kbd_cursor_wake_en;
    logic [4:0] suspend_minutes;
    logic [4:0] standby_minutes;
  } gxs_power_t;

  typedef struct packed {
    logic [5:0] c0_red;
    logic [5:0] c0_green;
    logic [5:0] c0_blue;
    logic [5:0] c1_red;
    logic [5:0] c1_green;
    logic [5:0] c1_blue;
    logic [10:0] hstart;
    logic [10:0] vstart;
    logic [5:0] hpreset;
    logic [5:0] vpreset;
    logic [3:0] pattern_sel;
    logic compat_visible;
  } gxs_cursor_t;

  typedef struct packed {
    logic [31:0] base;
    logic [1:0] size_code;
    logic [31:0] size_bytes;
    logic [31:0] fb_offset;
  } gxs_aperture_t;

  typedef struct packed {
    logic crc_en;
    logic edo_en;
    logic bypass_sram;
    logic [3:0] ctl_delay_ns;
    logic text_page_hit_en;
    logic dac_power_down;
    logic burst_write_en;
    logic continuous_access_en;
    logic req_grant_sync;
    logic [2:0] ras_precharge_mclk;
    logic [3:0] dram_cycle_mclk;
    logic swap_col_strobes;
  } gxs_memctl_t;

  typedef struct packed {
    logic cmd_queue_en;
    logic engine_prog_en;
    logic [1:0] screen_width_code;
    logic screen_width_invalid;
    logic [3:0] screen_start_hi;
    logic [6:0] cmd_queue_base;
  } gxs_engine_t;

  typedef struct packed {
    logic divide_by_2;
    logic [7:0] numerator;
    logic [5:0] denominator;
    logic [2:0] post_scale;
    logic vco_high_gain;
  } gxs_synth_t;

  // Writable bits of each index; zero means unmapped
  function automatic logic [7:0] reg_mask(input logic [5:0] idx);
    case (idx)
      IDX_SCRATCH0, IDX_SCRATCH1, IDX_SCRATCH2: reg_mask = MASK_FULL;
      IDX_POWER: reg_mask = MASK_POWER;
      IDX_C0_RED, IDX_C0_GREEN, IDX_C0_BLUE: reg_mask = MASK_SIX;
      IDX_C1_RED, IDX_C1_GREEN, IDX_C1_BLUE: reg_mask = MASK_SIX;
      IDX_HPRESET, IDX_VPRESET: reg_mask = MASK_SIX;
      IDX_HSTART_LO, IDX_VSTART_LO, IDX_LBASE_LO: reg_mask = MASK_FULL;
      IDX_HSTART_HI: reg_mask = MASK_THREE;
      IDX_VSTART_HI: reg_mask = MASK_VSTART_HI;
      IDX_LBASE_HI, IDX_CQ_BASE: reg_mask = MASK_SEVEN;
      IDX_TIMERS, IDX_MISC3, IDX_FB_LOC: reg_mask = MASK_FULL;
      IDX_ENGINE0, IDX_ENGINE1: reg_mask = MASK_ENGINE1;
      IDX_MCLK0, IDX_MCLK1, IDX_PCLK0, IDX_PCLK1: reg_mask = MASK_FULL;
      default: reg_mask = MASK_NONE;
    endcase
  endfunction

endpackage

/* hw/gxs_pin_sync.sv */
// Three-stage synchroniser for the monitor link pin levels
`timescale 1ns/1ns
module gxs_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] pin_in,
  output logic [1:0] level
);

  for (genvar g = 0; g < 2; g++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1 <= gxs_pkg::LINK_IDLE_LEVEL;
        s2 <= gxs_pkg::LINK_IDLE_LEVEL;
        s3 <= gxs_pkg::LINK_IDLE_LEVEL;
      end else begin
        s1 <= pin_in[g];
        s2 <= s1;
        s3 <= s2;
      end
    end
    // A new level is taken only once two late stages agree
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        level[g] <= gxs_pkg::LINK_IDLE_LEVEL;
      end else if (s2 == s3) begin
        level[g] <= s3;
      end
    end
  end

endmodule // gxs_pin_sync

/* hw/gxs_ext_regs.sv */
// Extended configuration register bank behind an index/data port pair
// Behaviour
// (R1) A 6-bit index written at the index port selects the data port target.
// (R2) Key 86h at the password index unlocks the bank; other values lock it.
// (R3) Three scratch registers store and return any byte, no side effect.
// (R4) Power bits 7 and 6 force suspend and standby while set.
// (R5) Power bits 5 and 4 enable memory and keyboard/cursor wake sources.
// (R6) Power bit 1 drives the link data line; reads return the line level.
// (R7) Power bit 0 drives the link clock line; reads return its level.
// (R8) Six cursor colour registers hold 6-bit components; bits 7:6 unused.
// (R9) Cursor horizontal start is 11 bits: low byte plus bits 2:0 above.
// (R10) Cursor vertical start is 11 bits: low byte plus bits 2:0 above.
// (R11) 4-bit pattern select in upper nibble; 6-bit horizontal, vertical presets.
// (R12) Aperture base bits 26:19 from one register, 31:27 from next bits 4:0.
// (R13) Aperture size code 00..11 selects 512 KB, 1 MB, 2 MB, 4 MB.
// (R14) Timer register: suspend upper nibble, standby lower, two minutes per step.
// (R15) Misc bit 7 drives the general output, inverted under negative polarity.
// (R16) Misc bits 6..3: CRC, EDO, SRAM bypass, compatible cursor visibility.
// (R17) Misc bits 2:0 select control delay from 4 ns to 11 ns.
// (R18) Frame buffer location counts 256 KB units, 512 KB on 64-bit memory.
// (R19) Engine 0 bit 2 gives 4-clock precharge, bit 1 gives 8-clock cycle.
// (R20) Engine 0 carries page-hit, DAC power-down, burst, access, sync, swap.
// (R21) Engine 1: queue enable, engine programming enable, start bits 19:16.
// (R22) 2-bit screen width code selects 1024/2048/4096; code 11 invalid.
// (R23) Clock synthesisers take numerator code+1 and a divide-by-two bit.
// (R24) Clock synthesisers take denominator code+1, post-scale 1..4, VCO gain.
// (R25) Reserved bits read zero and ignore writes; registers reset to zero, synchronised link levels to one.
`timescale 1ns/1ns
module gxs_ext_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_data_sel,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic gpio_polarity_neg,
  input wire logic mem_bus_64,
  output logic gpio_out,
  input wire logic monitor_link_data_in,
  output logic monitor_link_data_out,
  output logic monitor_link_data_oe_n,
  input wire logic monitor_link_clock_in,
  output logic monitor_link_clock_out,
  output logic monitor_link_clock_oe_n,
  output gxs_pkg::gxs_power_t power,
  output gxs_pkg::gxs_cursor_t cursor,
  output gxs_pkg::gxs_aperture_t aperture,
  output gxs_pkg::gxs_memctl_t memctl,
  output gxs_pkg::gxs_engine_t engine,
  output gxs_pkg::gxs_synth_t mem_clk_synth,
  output gxs_pkg::gxs_synth_t pixel_clk_synth
);

  logic [5:0] index;
  logic unlocked;
  logic [7:0] regs [0:63];
  logic [1:0] link_level;
  logic [7:0] next_rdata;
  logic data_wr;

  assign data_wr = io_wr && io_data_sel;

  gxs_pin_sync u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({monitor_link_data_in, monitor_link_clock_in}),
    .level(link_level)
  );

  // Index port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index <= '0;
    end else if (io_wr && !io_data_sel) begin
      index <= io_wdata[5:0]; // [R1]
    end
  end

  // Password lock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked <= 1'b0;
    end else if (data_wr && index == gxs_pkg::IDX_PASSWORD) begin
      unlocked <= (io_wdata == gxs_pkg::UNLOCK_KEY); // [R2]
    end
  end

  // Storage; unmapped indices have an all-zero mask and hold nothing
  for (genvar g = 0; g < 64; g++) begin : g_reg
    localparam logic [5:0] IDX = 6'(g);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        regs[g] <= gxs_pkg::RESET_VALUE; // [R25]
      end else if (data_wr && unlocked && index == IDX) begin
        regs[g] <= io_wdata & gxs_pkg::reg_mask(IDX); // [R3] [R25]
      end
    end
  end

  // Read path
  always_comb begin
    next_rdata = '0;
    if (!io_data_sel) begin
      next_rdata = {2'b00, index}; // [R1]
    end else if (index == gxs_pkg::IDX_PASSWORD) begin
      next_rdata = unlocked ? gxs_pkg::ID_UNLOCKED : gxs_pkg::ID_LOCKED;
    end else if (unlocked) begin
      next_rdata = regs[index] & gxs_pkg::reg_mask(index); // [R25]
      if (index == gxs_pkg::IDX_POWER) begin
        next_rdata[gxs_pkg::PWR_LINK_DATA] = link_level[1]; // [R6]
        next_rdata[gxs_pkg::PWR_LINK_CLOCK] = link_level[0]; // [R7]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= '0;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= io_rd;
      if (io_rd) begin
        io_rdata <= next_rdata;
      end
    end
  end

  // Open-drain link lines: a written 0 pulls the line low
  assign monitor_link_data_out = 1'b0;
  assign monitor_link_clock_out = 1'b0;
  assign monitor_link_data_oe_n =
    regs[gxs_pkg::IDX_POWER][gxs_pkg::PWR_LINK_DATA]; // [R6]
  assign monitor_link_clock_oe_n =
    regs[gxs_pkg::IDX_POWER][gxs_pkg::PWR_LINK_CLOCK]; // [R7]

  // Power management
  always_comb begin
    power.force_suspend = regs[gxs_pkg::IDX_POWER][7]; // [R4]
    power.force_standby = regs[gxs_pkg::IDX_POWER][6]; // [R4]
    power.vmem_wake_en = regs[gxs_pkg::IDX_POWER][5]; // [R5]
    power.kbd_cursor_wake_en = regs[gxs_pkg::IDX_POWER][4]; // [R5]
    power.suspend_minutes = 5'(regs[gxs_pkg::IDX_TIMERS][7:4]
      * gxs_pkg::TIMER_STEP_MIN); // [R14]
    power.standby_minutes = 5'(regs[gxs_pkg::IDX_TIMERS][3:0]
      * gxs_pkg::TIMER_STEP_MIN); // [R14]
  end

  // Cursor
  always_comb begin
    cursor.c0_red = regs[gxs_pkg::IDX_C0_RED][5:0]; // [R8]
    cursor.c0_green = regs[gxs_pkg::IDX_C0_GREEN][5:0];
    cursor.c0_blue = regs[gxs_pkg::IDX_C0_BLUE][5:0];
    cursor.c1_red = regs[gxs_pkg::IDX_C1_RED][5:0];
    cursor.c1_green = regs[gxs_pkg::IDX_C1_GREEN][5:0];
    cursor.c1_blue = regs[gxs_pkg::IDX_C1_BLUE][5:0];
    cursor.hstart = {regs[gxs_pkg::IDX_HSTART_HI][2:0],
      regs[gxs_pkg::IDX_HSTART_LO]}; // [R9]
    cursor.vstart = {regs[gxs_pkg::IDX_VSTART_HI][2:0],
      regs[gxs_pkg::IDX_VSTART_LO]}; // [R10]
    cursor.hpreset = regs[gxs_pkg::IDX_HPRESET][5:0]; // [R11]
    cursor.vpreset = regs[gxs_pkg::IDX_VPRESET][5:0]; // [R11]
    cursor.pattern_sel = regs[gxs_pkg::IDX_VSTART_HI][7:4]; // [R11]
    cursor.compat_visible = regs[gxs_pkg::IDX_MISC3][3]; // [R16]
  end

  // Linear aperture and frame buffer
  always_comb begin
    aperture.base = {regs[gxs_pkg::IDX_LBASE_HI][4:0],
      regs[gxs_pkg::IDX_LBASE_LO], 19'h0}; // [R12]
    aperture.size_code = regs[gxs_pkg::IDX_LBASE_HI][6:5]; // [R13]
    aperture.size_bytes = gxs_pkg::APERTURE_MIN_BYTES
      << aperture.size_code; // [R13]
    aperture.fb_offset = mem_bus_64 ?
      32'(regs[gxs_pkg::IDX_FB_LOC]) << gxs_pkg::FB_UNIT_SHIFT_64 :
      32'(regs[gxs_pkg::IDX_FB_LOC]) << gxs_pkg::FB_UNIT_SHIFT_32; // [R18]
  end

  // General output pin
  assign gpio_out = regs[gxs_pkg::IDX_MISC3][7] ^ gpio_polarity_neg; // [R15]

  // Memory control
  always_comb begin
    memctl.crc_en = regs[gxs_pkg::IDX_MISC3][6]; // [R16]
    memctl.edo_en = regs[gxs_pkg::IDX_MISC3][5]; // [R16]
    memctl.bypass_sram = regs[gxs_pkg::IDX_MISC3][4]; // [R16]
    memctl.ctl_delay_ns = gxs_pkg::DELAY_BASE_NS
      + {1'b0, regs[gxs_pkg::IDX_MISC3][2:0]}; // [R17]
    memctl.text_page_hit_en = regs[gxs_pkg::IDX_ENGINE0][7]; // [R20]
    memctl.dac_power_down = regs[gxs_pkg::IDX_ENGINE0][6]; // [R20]
    memctl.burst_write_en = regs[gxs_pkg::IDX_ENGINE0][5]; // [R20]
    memctl.continuous_access_en = regs[gxs_pkg::IDX_ENGINE0][4]; // [R20]
    memctl.req_grant_sync = regs[gxs_pkg::IDX_ENGINE0][3]; // [R20]
    memctl.ras_precharge_mclk = regs[gxs_pkg::IDX_ENGINE0][2] ?
      gxs_pkg::RAS_PRE_MCLK_SLOW : gxs_pkg::RAS_PRE_MCLK_FAST; // [R19]
    memctl.dram_cycle_mclk = regs[gxs_pkg::IDX_ENGINE0][1] ?
      gxs_pkg::DRAM_CYCLE_MCLK_SLOW : gxs_pkg::DRAM_CYCLE_MCLK_FAST; // [R19]
    memctl.swap_col_strobes = regs[gxs_pkg::IDX_ENGINE0][0]; // [R20]
  end

  // Drawing engine
  always_comb begin
    engine.cmd_queue_en = regs[gxs_pkg::IDX_ENGINE1][7]; // [R21]
    engine.engine_prog_en = regs[gxs_pkg::IDX_ENGINE1][6]; // [R21]
    engine.screen_width_code = regs[gxs_pkg::IDX_ENGINE1][5:4]; // [R22]
    engine.screen_width_invalid = regs[gxs_pkg::IDX_ENGINE1][5:4]
      == gxs_pkg::WIDTH_CODE_INVALID; // [R22]
    engine.screen_start_hi = regs[gxs_pkg::IDX_ENGINE1][3:0]; // [R21]
    engine.cmd_queue_base = regs[gxs_pkg::IDX_CQ_BASE][6:0];
  end

  // Clock synthesiser parameters, codes turned into values
  function automatic gxs_pkg::gxs_synth_t synth(input logic [7:0] r0,
                                                input logic [7:0] r1);
    gxs_pkg::gxs_synth_t s;
    s.divide_by_2 = r0[7]; // [R23]
    s.numerator = {1'b0, r0[6:0]} + 8'h01; // [R23]
    s.vco_high_gain = r1[7]; // [R24]
    s.post_scale = {1'b0, r1[6:5]} + 3'h1; // [R24]
    s.denominator = {1'b0, r1[4:0]} + 6'h01; // [R24]
    return s;
  endfunction

  assign mem_clk_synth =
    synth(regs[gxs_pkg::IDX_MCLK0], regs[gxs_pkg::IDX_MCLK1]);
  assign pixel_clk_synth =
    synth(regs[gxs_pkg::IDX_PCLK0], regs[gxs_pkg::IDX_PCLK1]);

  // Checks
  property p_index_held;
    @(posedge clk) disable iff (!rst_n)
    io_wr && !io_data_sel |=> index == $past(io_wdata[5:0]);
  endproperty
  a_index_held: assert property (p_index_held) // [R1]
    else $error("index port readback wrong");

  property p_unlock;
    @(posedge clk) disable iff (!rst_n)
    data_wr && index == gxs_pkg::IDX_PASSWORD
      |=> unlocked == ($past(io_wdata) == gxs_pkg::UNLOCK_KEY);
  endproperty
  a_unlock: assert property (p_unlock) // [R2]
    else $error("lock state does not follow password write");

  property p_locked_no_write;
    @(posedge clk) disable iff (!rst_n)
    data_wr && !unlocked |=> $stable(regs[gxs_pkg::IDX_SCRATCH0])
      && $stable(regs[gxs_pkg::IDX_TIMERS]);
  endproperty
  a_locked_no_write: assert property (p_locked_no_write) // [R2]
    else $error("write landed while bank locked");

  property p_scratch;
    @(posedge clk) disable iff (!rst_n)
    data_wr && unlocked && index == gxs_pkg::IDX_SCRATCH2
      |=> regs[gxs_pkg::IDX_SCRATCH2] == $past(io_wdata);
  endproperty
  a_scratch: assert property (p_scratch) // [R3]
    else $error("scratch register did not store the byte");

  property p_suspend;
    @(posedge clk) disable iff (!rst_n)
    data_wr && unlocked && index == gxs_pkg::IDX_POWER
      |=> power.force_suspend == $past(io_wdata[7])
      && power.force_standby == $past(io_wdata[6]);
  endproperty
  a_suspend: assert property (p_suspend) // [R4]
    else $error("forced power state not following write");

  property p_link_drive;
    @(posedge clk) disable iff (!rst_n)
    data_wr && unlocked && index == gxs_pkg::IDX_POWER
      |=> monitor_link_data_oe_n == $past(io_wdata[1])
      && monitor_link_clock_oe_n == $past(io_wdata[0]);
  endproperty
  a_link_drive: assert property (p_link_drive) // [R6]
    else $error("link line drive not following write");

  property p_link_read;
    @(posedge clk) disable iff (!rst_n)
    io_rd && io_data_sel && unlocked && index == gxs_pkg::IDX_POWER
      |=> io_rdata[1:0] == $past(link_level);
  endproperty
  a_link_read: assert property (p_link_read) // [R7]
    else $error("link level not returned on read");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n)
    io_rd && io_data_sel && index == gxs_pkg::IDX_C1_BLUE
      |=> io_rdata[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R8]
    else $error("reserved colour bits read nonzero");

  property p_gpio;
    @(posedge clk) disable iff (!rst_n)
    data_wr && unlocked && index == gxs_pkg::IDX_MISC3
      |=> gpio_out == ($past(io_wdata[7]) ^ gpio_polarity_neg);
  endproperty
  a_gpio: assert property (p_gpio) // [R15]
    else $error("general output level wrong");

  property p_hstart;
    @(posedge clk) disable iff (!rst_n)
    data_wr && unlocked && index == gxs_pkg::IDX_HSTART_HI
      |=> cursor.hstart[10:8] == $past(io_wdata[2:0]);
  endproperty
  a_hstart: assert property (p_hstart) // [R9]
    else $error("cursor start high bits wrong");

  property p_locked_read;
    @(posedge clk) disable iff (!rst_n)
    io_rd && io_data_sel && !unlocked && index != gxs_pkg::IDX_PASSWORD
      |=> io_rdata == 8'h00;
  endproperty
  a_locked_read: assert property (p_locked_read) // [R2]
    else $error("locked bank returned data");

  property p_power_reserved;
    @(posedge clk) disable iff (!rst_n)
    io_rd && io_data_sel && unlocked && index == gxs_pkg::IDX_POWER
      |=> io_rdata[3:2] == 2'b00;
  endproperty
  a_power_reserved: assert property (p_power_reserved) // [R25]
    else $error("reserved power bits read nonzero");

  // A low pin held two samples must reach the read level
  property p_link_sync;
    @(posedge clk) disable iff (!rst_n)
    $fell(monitor_link_data_in) ##1 !monitor_link_data_in
      |-> ##3 !link_level[1];
  endproperty
  a_link_sync: assert property (p_link_sync) // [R6]
    else $error("link data level not taken from the pin");

  c_unlock: cover property (@(posedge clk) disable iff (!rst_n)
    !unlocked ##1 unlocked);
  c_link_low: cover property (@(posedge clk) disable iff (!rst_n)
    !monitor_link_clock_oe_n && io_rdata_valid);
  c_gpio_neg: cover property (@(posedge clk) disable iff (!rst_n)
    gpio_polarity_neg && gpio_out);
  c_relock: cover property (@(posedge clk) disable iff (!rst_n)
    unlocked ##1 !unlocked);
  c_line_held_low: cover property (@(posedge clk) disable iff (!rst_n)
    monitor_link_data_oe_n && !link_level[1]);

endmodule // gxs_ext_regs

/* testbench/tb.sv */
// Self-checking random testbench for the extended register bank
`timescale 1ns/1ns
module tb;
  logic clk, rst_n, io_wr, io_rd, io_data_sel, pol, mem_bus_64;
  logic [7:0] io_wdata, io_rdata, v;
  logic io_rdata_valid, gpio_out, d_out, d_oe_n, c_out, c_oe_n;
  wire logic d_in, c_in;
  gxs_pkg::gxs_power_t power;
  gxs_pkg::gxs_cursor_t cursor;
  gxs_pkg::gxs_aperture_t aperture;
  gxs_pkg::gxs_memctl_t memctl;
  gxs_pkg::gxs_engine_t engine;
  gxs_pkg::gxs_synth_t msyn, psyn;
  integer seed = 92;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] sh [64];
  logic ext_low = 1'b0;
  // Open-drain lines with pull-ups; ext_low is another device pulling data
  assign d_in = (d_oe_n ? 1'b1 : d_out) & ~ext_low;
  assign c_in = c_oe_n ? 1'b1 : c_out;
  gxs_ext_regs gxs_ext_regs_i (.clk(clk), .rst_n(rst_n), .io_wr(io_wr),
    .io_rd(io_rd), .io_data_sel(io_data_sel), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .gpio_polarity_neg(pol), .mem_bus_64(mem_bus_64), .gpio_out(gpio_out),
    .monitor_link_data_in(d_in), .monitor_link_data_out(d_out),
    .monitor_link_data_oe_n(d_oe_n), .monitor_link_clock_in(c_in),
    .monitor_link_clock_out(c_out), .monitor_link_clock_oe_n(c_oe_n),
    .power(power), .cursor(cursor), .aperture(aperture), .memctl(memctl),
    .engine(engine), .mem_clk_synth(msyn), .pixel_clk_synth(psyn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One write strobe followed by an idle cycle
  task automatic put(input logic sel, input logic [7:0] d);
    io_data_sel = sel;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1 io_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    put(1'b0, i);
    put(1'b1, d);
  endtask
  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    put(1'b0, i);
    io_rd = 1'b1;
    @(posedge clk);
    #1 io_data_sel = 1'b1;
    chk(io_rdata, {2'b00, i[5:0]});
    @(posedge clk);
    #1 io_rd = 1'b0;
    chk(io_rdata_valid, 1);
    chk(io_rdata, e);
  endtask
  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      8'h0F, 8'h10, 8'h1A, 8'h1D, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
      8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B: msk = 8'hFF;
      8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1C, 8'h1F: msk = 8'h3F;
      8'h1B: msk = 8'h07;
      8'h1E: msk = 8'hF7;
      8'h21, 8'h2C: msk = 8'h7F;
      default: msk = 8'h00;
    endcase
  endfunction
  task automatic decode;
    chk(cursor.c1_blue, sh[8'h19]);
    chk(cursor.hstart, {sh[8'h1B][2:0], sh[8'h1A]});
    chk(cursor.vstart, {sh[8'h1E][2:0], sh[8'h1D]});
    chk(cursor.pattern_sel, sh[8'h1E][7:4]);
    chk(cursor.vpreset, sh[8'h1F]);
    chk(aperture.base, {sh[8'h21][4:0], sh[8'h20], 19'h0});
    chk(aperture.size_bytes, 32'h80000 << sh[8'h21][6:5]);
    chk(power.suspend_minutes, {sh[8'h22][7:4], 1'b0});
    chk(power.standby_minutes, {sh[8'h22][3:0], 1'b0});
    chk(gpio_out, sh[8'h23][7] ^ pol);
    chk({memctl.crc_en, memctl.edo_en, memctl.bypass_sram,
      cursor.compat_visible}, sh[8'h23][6:3]);
    chk(memctl.ctl_delay_ns, 4 + sh[8'h23][2:0]);
    chk(aperture.fb_offset, 32'(sh[8'h24]) << (mem_bus_64 ? 19 : 18));
    chk(memctl.ras_precharge_mclk, sh[8'h26][2] ? 4 : 3);
    chk(memctl.dram_cycle_mclk, sh[8'h26][1] ? 8 : 7);
    chk({memctl.text_page_hit_en, memctl.swap_col_strobes},
      {sh[8'h26][7], sh[8'h26][0]});
    chk({engine.cmd_queue_en, engine.screen_start_hi},
      {sh[8'h27][7], sh[8'h27][3:0]});
    chk(engine.screen_width_invalid, sh[8'h27][5:4] == 2'h3);
    chk(msyn.numerator, sh[8'h28][6:0] + 1);
    chk(psyn.divide_by_2, sh[8'h2A][7]);
    chk(msyn.denominator, sh[8'h29][4:0] + 1);
    chk(psyn.post_scale, sh[8'h2B][6:5] + 1);
    chk(msyn.post_scale, sh[8'h29][6:5] + 1);
    chk(psyn.denominator, sh[8'h2B][4:0] + 1);
    chk({msyn.vco_high_gain, psyn.vco_high_gain},
      {sh[8'h29][7], sh[8'h2B][7]});
    chk(psyn.numerator, sh[8'h2A][6:0] + 1);
    chk(msyn.divide_by_2, sh[8'h28][7]);
    chk({cursor.c0_red, cursor.c0_green, cursor.c0_blue},
      {sh[8'h14][5:0], sh[8'h15][5:0], sh[8'h16][5:0]});
    chk({cursor.c1_red, cursor.c1_green},
      {sh[8'h17][5:0], sh[8'h18][5:0]});
    chk(cursor.hpreset, sh[8'h1C]);
    chk(aperture.size_code, sh[8'h21][6:5]);
    chk({memctl.dac_power_down, memctl.burst_write_en,
      memctl.continuous_access_en, memctl.req_grant_sync},
      sh[8'h26][6:3]);
    chk(engine.engine_prog_en, sh[8'h27][6]);
    chk(engine.screen_width_code, sh[8'h27][5:4]);
    chk(engine.cmd_queue_base, sh[8'h2C]);
  endtask
  initial begin
    #200000 num_errors++;
    print_verdict;
  end
  initial begin
    {io_wr, io_rd, io_data_sel, pol, mem_bus_64, rst_n} = 6'h00;
    io_wdata = 8'h00;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(gpio_out, pol);
    rreg(8'h05, 8'h21);
    wreg(8'h0F, 8'h5A);
    wreg(8'h05, 8'h86);
    rreg(8'h05, 8'hA1);
    for (int i = 6; i < 8'h38; i++) rreg(i, 8'h00);
    $display("test reset and lock done");
    for (int r = 0; r < 3; r++) begin
      pol = r[0];
      mem_bus_64 = r[0];
      for (int i = 6; i < 8'h38; i++) begin
        v = (r == 0) ? 8'hFF : 8'($random(seed));
        sh[i] = v & msk(i);
        if (i != 8'h11) wreg(i, v);
      end
      for (int i = 6; i < 8'h38; i++)
        if (i != 8'h11) rreg(i, sh[i]);
      decode;
    end
    $display("test random fields done");
    wreg(8'h05, 8'h33);
    rreg(8'h05, 8'h21);
    wreg(8'h10, 8'hC3);
    rreg(8'h10, 8'h00);
    wreg(8'h05, 8'h86);
    rreg(8'h10, sh[8'h10]);
    $display("test relock done");
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      wreg(8'h11, v);
      repeat (5) @(posedge clk);
      #1 rreg(8'h11, {v[7:4], 2'b00, v[1:0]});
      chk({d_oe_n, c_oe_n}, v[1:0]);
      chk({power.force_suspend, power.force_standby}, v[7:6]);
      chk({power.vmem_wake_en, power.kbd_cursor_wake_en}, v[5:4]);
      chk({d_out, c_out}, 2'b00);
    end
    wreg(8'h11, 8'h03);
    ext_low = 1'b1;
    repeat (5) @(posedge clk);
    #1 rreg(8'h11, 8'h01);
    ext_low = 1'b0;
    $display("test power and link done");
    print_verdict;
  end
endmodule // tb
